// >>> ldr_defines.svh
// Operation
// - Four separate lane shift registers, each gathering seven serial bits per link period.
// - Lane bits are sampled at seven times the link clock rate.
// - Once per link period all four lanes move to the 28-bit word output.
// - A multiplied bit clock drives sampling; a pixel clock accompanies every output word.
// - Output word stays stable around the pixel clock falling edge.
// - Shutdown low stops internal clocking and turns the lane receivers off; here both clocks keep running and the logic is held in clear instead.
// - Shutdown low clears every register except the synchronisers and floats word and pixel clock pins.
// - After shutdown rises the word is flagged invalid for the 1 ms enable time.
// - After shutdown falls the outputs are off within 400 ns.
// - Output word equals the transmitter input word bit for bit.
// - Three-lane transmitters work too; the fourth lane outputs are then meaningless.
`ifndef LDR_DEFINES_SVH
`define LDR_DEFINES_SVH
`define LDR_LANES 4
`define LDR_SLOT_BITS 7
`define LDR_WORD_W 28
`define LDR_CORE_PERIOD_NS 10
`define LDR_EN_TIME_MS 1
`define LDR_EN_CYC (`LDR_EN_TIME_MS * 1000000 / `LDR_CORE_PERIOD_NS)
`define LDR_DIS_TIME_NS 400
`define LDR_DIS_CYC (`LDR_DIS_TIME_NS / `LDR_CORE_PERIOD_NS)
`define LDR_LOCK_PERIODS 4
`define LDR_PIX_HIGH_CYC 2
`define LDR_SLOT_LAST 3'h6
`endif

// >>> ldr_deser.sv
`timescale 1ns/1ns
`include "ldr_defines.svh"
module ldr_deser #(
  parameter int EN_CYC       = `LDR_EN_CYC,
  parameter int LOCK_PERIODS = `LDR_LOCK_PERIODS,
  parameter int PIX_HIGH     = `LDR_PIX_HIGH_CYC
) (
  // Core clock domain
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   core_ce_i,
  // Bit clock from the multiplying PLL
  input  wire logic                   bit_clk_i,
  // Link pins
  input  wire logic                   link_clock_in_pos_i,
  input  wire logic                   link_clock_in_neg_i,
  input  wire logic [`LDR_LANES-1:0]  serial_lane_pos_i,
  input  wire logic [`LDR_LANES-1:0]  serial_lane_neg_i,
  input  wire logic                   shutdown_clear_n_i,
  // Display side
  output logic [`LDR_WORD_W-1:0]      parallel_word_out_o,
  output logic                        parallel_word_oe_o,
  output logic                        pixel_clock_out_o,
  output logic                        pixel_clock_oe_o,
  output logic                        word_valid_o,
  output logic                        lane_rx_en_o
);
  localparam int EnW  = $clog2(EN_CYC + 1);
  localparam int LkW  = $clog2(LOCK_PERIODS + 1);
  localparam int DisCyc = `LDR_DIS_CYC;
  localparam logic [EnW-1:0] EnTop   = EnW'(EN_CYC - 1);
  localparam logic [LkW-1:0] LkTop   = LkW'(LOCK_PERIODS - 1);
  localparam logic [1:0]     PixTop  = 2'(PIX_HIGH - 1);

  if (EN_CYC < 1 || LOCK_PERIODS < 1 || PIX_HIGH < 1 || PIX_HIGH > 3) begin : g_bad_param
    $error("ldr_deser: parameter out of range");
  end

  // Bit clock domain: pin synchronisers.
  logic rst_b1_r, rst_b2_r, shdn_b1_r, shdn_b2_r;
  logic lkp1_r, lkp2_r, lkn1_r, lkn2_r;

  always_ff @(posedge bit_clk_i) begin
    rst_b1_r  <= rst_i;
    rst_b2_r  <= rst_b1_r;
    shdn_b1_r <= shutdown_clear_n_i;
    shdn_b2_r <= shdn_b1_r;
    lkp1_r    <= link_clock_in_pos_i;
    lkp2_r    <= lkp1_r;
    lkn1_r    <= link_clock_in_neg_i;
    lkn2_r    <= lkn1_r;
  end

  logic bclr;
  assign bclr = rst_b2_r | ~shdn_b2_r;

  ldr_pkg::ldr_slot_t lane_bits [`LDR_LANES];
  logic [`LDR_WORD_W-1:0] mapped;

  // Lane n carries word bits 7n..7n+6, first serial bit into bit 7n+6.
  for (genvar g = 0; g < `LDR_LANES; g++) begin : g_lane
    ldr_lane_shift u_lane (
      .bit_clk_i  (bit_clk_i),
      .clr_i      (bclr),
      .lane_pos_i (serial_lane_pos_i[g]),
      .lane_neg_i (serial_lane_neg_i[g]),
      .shreg_o    (lane_bits[g])
    );
    assign mapped[g*`LDR_SLOT_BITS +: `LDR_SLOT_BITS] = lane_bits[g];
  end

  // Bit clock domain: link clock edge, slot counter, lock and word capture.
  logic                   lk_prev_r, lk_prev_nxt;
  logic [2:0]             bit_cnt_r, bit_cnt_nxt;
  logic [LkW-1:0]         good_r, good_nxt;
  logic                   locked_r, locked_nxt;
  logic [`LDR_WORD_W-1:0] slot_word_r, slot_word_nxt;
  logic                   tog_r, tog_nxt;
  logic                   lk_now, lk_edge;

  assign lk_now  = lkp2_r & ~lkn2_r;
  assign lk_edge = lk_now & ~lk_prev_r;

  always_comb begin
    lk_prev_nxt   = lk_now;
    bit_cnt_nxt   = (bit_cnt_r == 3'h7) ? bit_cnt_r : bit_cnt_r + 3'h1;
    good_nxt      = good_r;
    locked_nxt    = locked_r;
    slot_word_nxt = slot_word_r;
    tog_nxt       = tog_r;
    if (lk_edge) begin
      bit_cnt_nxt = 3'h0;
      // Seven bits between edges means the multiplied clock tracks the link.
      if (bit_cnt_r == `LDR_SLOT_LAST) begin
        good_nxt   = (good_r == LkTop) ? good_r : good_r + LkW'(1);
        locked_nxt = locked_r | (good_r == LkTop);
      end else begin
        good_nxt   = '0;
        locked_nxt = 1'b0;
      end
      // A word is handed over only when its slot came from a single period.
      if (locked_r && bit_cnt_r == `LDR_SLOT_LAST) begin
        slot_word_nxt = mapped;
        tog_nxt       = ~tog_r;
      end
    end
    if (bclr) begin
      lk_prev_nxt   = 1'b0;
      bit_cnt_nxt   = 3'h0;
      good_nxt      = '0;
      locked_nxt    = 1'b0;
      slot_word_nxt = '0;
      tog_nxt       = 1'b0;
    end
  end

  always_ff @(posedge bit_clk_i) begin
    lk_prev_r   <= lk_prev_nxt;
    bit_cnt_r   <= bit_cnt_nxt;
    good_r      <= good_nxt;
    locked_r    <= locked_nxt;
    slot_word_r <= slot_word_nxt;
    tog_r       <= tog_nxt;
  end

  // Core domain synchronisers, frozen with the clock enable.
  logic shdn_c1_r, shdn_c2_r, tog_c1_r, tog_c2_r, tog_c3_r, lock_c1_r, lock_c2_r;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      shdn_c1_r <= 1'b0;
      shdn_c2_r <= 1'b0;
      tog_c1_r  <= 1'b0;
      tog_c2_r  <= 1'b0;
      tog_c3_r  <= 1'b0;
      lock_c1_r <= 1'b0;
      lock_c2_r <= 1'b0;
    end else if (core_ce_i) begin
      shdn_c1_r <= shutdown_clear_n_i;
      shdn_c2_r <= shdn_c1_r;
      tog_c1_r  <= tog_r;
      tog_c2_r  <= tog_c1_r;
      tog_c3_r  <= tog_c2_r;
      lock_c1_r <= locked_r;
      lock_c2_r <= lock_c1_r;
    end
  end

  // The captured word holds a whole link period, far longer than the toggle takes to cross.
  logic new_word;
  assign new_word = tog_c2_r ^ tog_c3_r;

  // Core domain: enable timing, output word and regenerated pixel clock.
  ldr_pkg::ldr_state_t state_r, state_nxt;
  logic [EnW-1:0]      en_cnt_r, en_cnt_nxt;
  logic [1:0]          pcnt_r, pcnt_nxt;
  ldr_pkg::ldr_out_t   out_r, out_nxt;

  always_comb begin
    state_nxt  = state_r;
    en_cnt_nxt = en_cnt_r;
    pcnt_nxt   = pcnt_r;
    out_nxt    = out_r;
    case (state_r)
      ldr_pkg::LDR_OFF: begin
        state_nxt     = ldr_pkg::LDR_WAIT;
        en_cnt_nxt    = '0;
        out_nxt.oe    = 1'b1;
        out_nxt.rx_en = 1'b1;
      end
      ldr_pkg::LDR_WAIT: begin
        // The word is flagged invalid until the enable time has run out.
        en_cnt_nxt = en_cnt_r + EnW'(1);
        if (en_cnt_r == EnTop) begin
          en_cnt_nxt = en_cnt_r;
          state_nxt  = ldr_pkg::LDR_RUN;
        end
      end
      ldr_pkg::LDR_RUN: begin
        out_nxt.valid = lock_c2_r;
      end
      default: begin
        state_nxt = ldr_pkg::LDR_OFF;
      end
    endcase
    if (state_r != ldr_pkg::LDR_OFF && new_word) begin
      // Word changes with the pixel clock rise, so it is settled long before the fall.
      out_nxt.word = slot_word_r;
      out_nxt.pix  = 1'b1;
      pcnt_nxt     = PixTop;
    end else if (out_r.pix) begin
      if (pcnt_r == 2'h0) begin
        out_nxt.pix = 1'b0;
      end else begin
        pcnt_nxt = pcnt_r - 2'h1;
      end
    end
    if (!shdn_c2_r) begin
      state_nxt  = ldr_pkg::LDR_OFF;
      en_cnt_nxt = '0;
      pcnt_nxt   = 2'h0;
      out_nxt    = '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_r  <= ldr_pkg::LDR_OFF;
      en_cnt_r <= '0;
      pcnt_r   <= 2'h0;
      out_r    <= '0;
    end else if (core_ce_i) begin
      state_r  <= state_nxt;
      en_cnt_r <= en_cnt_nxt;
      pcnt_r   <= pcnt_nxt;
      out_r    <= out_nxt;
    end
  end

  assign parallel_word_out_o = out_r.word;
  assign parallel_word_oe_o  = out_r.oe;
  assign pixel_clock_out_o   = out_r.pix;
  assign pixel_clock_oe_o    = out_r.oe;
  assign word_valid_o        = out_r.valid;
  assign lane_rx_en_o        = out_r.rx_en;

  // Checks in the core domain.
  sequence s_shut_held;
    (!shutdown_clear_n_i && core_ce_i) [*3];
  endsequence

  property p_off_after_shut;
    @(posedge core_clk_i) disable iff (rst_i)
      s_shut_held |=> !parallel_word_oe_o && !pixel_clock_oe_o && parallel_word_out_o == '0;
  endproperty
  a_off_after_shut: assert property (p_off_after_shut) else $error("outputs not off");

  property p_rx_off;
    @(posedge core_clk_i) disable iff (rst_i)
      s_shut_held |=> !lane_rx_en_o && !word_valid_o && !pixel_clock_out_o;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receivers still on");

  property p_disable_time;
    @(posedge core_clk_i) disable iff (rst_i || !core_ce_i)
      ($fell(shutdown_clear_n_i) ##1 !shutdown_clear_n_i [*3])
        |-> ##[0:DisCyc] !parallel_word_oe_o;
  endproperty
  a_disable_time: assert property (p_disable_time) else $error("disable too slow");

  property p_enable_time;
    @(posedge core_clk_i) disable iff (rst_i)
      word_valid_o |-> en_cnt_r == EnTop && state_r == ldr_pkg::LDR_RUN;
  endproperty
  a_enable_time: assert property (p_enable_time) else $error("valid too early");

  sequence s_fall;
    $fell(pixel_clock_out_o) && core_ce_i;
  endsequence

  property p_stable_fall;
    @(posedge core_clk_i) disable iff (rst_i || !shdn_c2_r)
      s_fall |-> $stable(parallel_word_out_o) ##1 $stable(parallel_word_out_o);
  endproperty
  a_stable_fall: assert property (p_stable_fall) else $error("word moved at fall");

  property p_word_with_clock;
    @(posedge core_clk_i) disable iff (rst_i || !shdn_c2_r || !core_ce_i)
      new_word |=> pixel_clock_out_o && parallel_word_out_o == slot_word_r
        ##PIX_HIGH !pixel_clock_out_o;
  endproperty
  a_word_with_clock: assert property (p_word_with_clock) else $error("word/clock mismatch");

  // Checks in the bit clock domain.
  property p_slot_count;
    @(posedge bit_clk_i) disable iff (bclr)
      (!lk_edge && bit_cnt_r != 3'h7) |=> bit_cnt_r == $past(bit_cnt_r) + 3'h1;
  endproperty
  a_slot_count: assert property (p_slot_count) else $error("bit count slipped");

  property p_capture_aligned;
    @(posedge bit_clk_i) disable iff (bclr)
      (tog_r != $past(tog_r)) |-> $past(lk_edge) && $past(bit_cnt_r) == `LDR_SLOT_LAST
        && $past(locked_r) && slot_word_r == $past(mapped);
  endproperty
  a_capture_aligned: assert property (p_capture_aligned) else $error("misaligned capture");

  property p_bit_clear;
    @(posedge bit_clk_i) bclr |=> slot_word_r == '0 && !locked_r && !tog_r;
  endproperty
  a_bit_clear: assert property (p_bit_clear) else $error("bit domain not cleared");
endmodule : ldr_deser

// >>> ldr_deser_tb.sv
`timescale 1ns/1ns
`include "ldr_defines.svh"
module ldr_deser_tb;
  typedef struct packed {
    logic [`LDR_WORD_W-1:0] tx;
    logic [`LDR_WORD_W-1:0] exp;
  } ldr_row_t;
  logic                   core_clk_i, rst_i, sd_n, en, short_f, three_f, ce, pix_prev;
  logic                   bit_clk, lk_p, lk_n, w_oe, pix, pix_oe, valid, rx_en;
  logic [`LDR_LANES-1:0]  ln_p, ln_n;
  logic [`LDR_WORD_W-1:0] word, pw, got;
  int                     fails, cmp_count, cnt;
  ldr_row_t rows [5] = '{'{28'hFFFFFFF, 28'hFFFFFFF}, '{28'h0000000, 28'h0000000},
                        '{28'h8000001, 28'h8000001}, '{28'h5A5A5A5, 28'h5A5A5A5},
                        '{28'h1234567, 28'h1234567}};
  ldr_tx_model tx (.en_i(en), .short_i(short_f), .three_lane_i(three_f), .word_i(word),
    .bit_clk_o(bit_clk), .link_pos_o(lk_p), .link_neg_o(lk_n), .lane_pos_o(ln_p),
    .lane_neg_o(ln_n));
  ldr_deser #(.EN_CYC(20), .LOCK_PERIODS(4), .PIX_HIGH(2)) dut (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .core_ce_i(ce), .bit_clk_i(bit_clk), .link_clock_in_pos_i(lk_p),
    .link_clock_in_neg_i(lk_n), .serial_lane_pos_i(ln_p), .serial_lane_neg_i(ln_n),
    .shutdown_clear_n_i(sd_n), .parallel_word_out_o(pw), .parallel_word_oe_o(w_oe),
    .pixel_clock_out_o(pix), .pixel_clock_oe_o(pix_oe), .word_valid_o(valid),
    .lane_rx_en_o(rx_en));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic check(input logic [`LDR_WORD_W-1:0] seen, input logic [`LDR_WORD_W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : step
  task automatic bail();
    fails++;
    $display("BAD %0t wait ran out", $time);
    stop_test();
  endtask : bail
  // Takes one word at the pixel clock fall and checks it held since the rise.
  task automatic grab(output logic [`LDR_WORD_W-1:0] w);
    logic [`LDR_WORD_W-1:0] at_rise;
    int                     i;
    i = 0;
    while (pix !== 1'b0 && i < 100) begin step(1); i++; end
    while (pix !== 1'b1 && i < 100) begin step(1); i++; end
    at_rise = pw;
    while (pix !== 1'b0 && i < 100) begin step(1); i++; end
    if (i >= 100) bail();
    w = pw;
    check(w, at_rise);
  endtask : grab
  task automatic wait_valid();
    int i;
    i = 0;
    while (valid !== 1'b1 && i < 500) begin step(1); i++; end
    if (i >= 500) bail();
  endtask : wait_valid
  initial begin
    fails = 0; cmp_count = 0; rst_i = 1'b1; sd_n = 1'b1; en = 1'b1;
    short_f = 1'b0; three_f = 1'b0; word = 28'h0000000;
    ce = 1'b1;
    step(4);
    check(28'({w_oe, pix_oe, pix, valid, rx_en}), 28'h0);
    rst_i = 1'b0;
    wait_valid();
    check(28'({w_oe, pix_oe, rx_en}), 28'h7);
    $display("reset test done");
    foreach (rows[r]) begin
      word = rows[r].tx;
      grab(got); grab(got); grab(got);
      check(got, rows[r].exp);
    end
    $display("word table done");
    cnt = 0;
    pix_prev = pix;
    for (int c = 0; c < 320; c++) begin
      step(1);
      if (pix === 1'b1 && pix_prev === 1'b0) cnt++;
      pix_prev = pix;
    end
    check(28'(cnt >= 49 && cnt <= 51), 28'h1);
    $display("pixel rate test done");
    three_f = 1'b1; word = 28'h0ABCDEF;
    grab(got); grab(got); grab(got);
    check(got & 28'h01FFFFF, 28'h00BCDEF);
    three_f = 1'b0;
    $display("three lane test done");
    short_f = 1'b1; word = 28'h3C3C3C3;
    step(20);
    cnt = 0;
    for (int c = 0; c < 100; c++) begin step(1); if (pix === 1'b1) cnt++; end
    check(28'(cnt), 28'h0);
    short_f = 1'b0;
    grab(got); grab(got);
    check(got, 28'h3C3C3C3);
    $display("alignment test done");
    sd_n = 1'b0;
    step(3);
    check(28'({w_oe, pix_oe, pix, valid, rx_en}), 28'h0);
    check(pw, 28'h0);
    step(10);
    // A frozen core must not see the release, so the pins stay off.
    ce = 1'b0;
    sd_n = 1'b1;
    step(10);
    check(28'({w_oe, pix_oe, rx_en}), 28'h0);
    ce = 1'b1;
    step(4);
    check(28'({w_oe, valid}), 28'h2);
    step(8);
    check(28'(valid), 28'h0);
    wait_valid();
    grab(got); grab(got);
    check(got, 28'h3C3C3C3);
    $display("shutdown test done");
    stop_test();
  end
endmodule : ldr_deser_tb

// >>> ldr_lane_shift.sv
`timescale 1ns/1ns
`include "ldr_defines.svh"
module ldr_lane_shift (
  // Bit clock domain
  input  wire logic          bit_clk_i,
  input  wire logic          clr_i,
  // Differential lane
  input  wire logic          lane_pos_i,
  input  wire logic          lane_neg_i,
  // Gathered bits
  output ldr_pkg::ldr_slot_t shreg_o
);
  logic               pos1_r, pos2_r, neg1_r, neg2_r;
  ldr_pkg::ldr_slot_t sh_r, sh_nxt;

  always_ff @(posedge bit_clk_i) begin
    pos1_r <= lane_pos_i;
    pos2_r <= pos1_r;
    neg1_r <= lane_neg_i;
    neg2_r <= neg1_r;
  end

  // One new bit enters per bit clock; the oldest bit ends at the top.
  always_comb begin
    sh_nxt = clr_i ? '0 : {sh_r[`LDR_SLOT_BITS-2:0], pos2_r & ~neg2_r};
  end

  always_ff @(posedge bit_clk_i) begin
    sh_r <= sh_nxt;
  end

  assign shreg_o = sh_r;
endmodule : ldr_lane_shift

// >>> ldr_pkg.sv
`include "ldr_defines.svh"
package ldr_pkg;
  typedef enum logic [1:0] {LDR_OFF, LDR_WAIT, LDR_RUN} ldr_state_t;
  typedef logic [`LDR_SLOT_BITS-1:0] ldr_slot_t;
  typedef struct packed {
    logic [`LDR_WORD_W-1:0] word;
    logic                   oe;
    logic                   pix;
    logic                   valid;
    logic                   rx_en;
  } ldr_out_t;
endpackage : ldr_pkg

// >>> ldr_tx_model.sv
`timescale 1ns/1ns
`include "ldr_defines.svh"
module ldr_tx_model (
  // Control from the bench
  input  wire logic                  en_i,
  input  wire logic                  short_i,
  input  wire logic                  three_lane_i,
  input  wire logic [`LDR_WORD_W-1:0] word_i,
  // Link side
  output logic                       bit_clk_o,
  output logic                       link_pos_o,
  output logic                       link_neg_o,
  output logic [`LDR_LANES-1:0]      lane_pos_o,
  output logic [`LDR_LANES-1:0]      lane_neg_o
);
  logic [`LDR_WORD_W-1:0] frm;
  int                     len;
  initial begin
    bit_clk_o  = 1'b0;
    link_pos_o = 1'b0;
    link_neg_o = 1'b1;
    lane_pos_o = 4'h0;
    lane_neg_o = 4'hF;
    forever begin
      // Frames run at 64 ns, below the lock range, so a 100 MHz core keeps up.
      len = short_i ? 6 : 7;
      frm = word_i;
      for (int k = 0; k < len; k++) begin
        // Lines change on the falling bit edge so the sampling edge sees settled data.
        link_pos_o = en_i && (k < 4);
        if (en_i) begin
          for (int n = 0; n < `LDR_LANES; n++) lane_pos_o[n] = frm[7*n+6-k];
          if (three_lane_i) lane_pos_o[3] = ~lane_pos_o[3];
        end else begin
          lane_pos_o = ~lane_pos_o;
        end
        link_neg_o = ~link_pos_o;
        lane_neg_o = ~lane_pos_o;
        #4 bit_clk_o = 1'b1;
        #5 bit_clk_o = 1'b0;
      end
      // Stretch the frame to 64 ns, since 64/7 ns does not fit a 1 ns grid.
      #1;
    end
  end
endmodule : ldr_tx_model
